// File: hw/lbfm_fault_mgr.sv
/*
 * Fault manager for a multi-string LED boost driver: channel removal,
 * overvoltage hold, latched shutdowns and dimming/undervoltage clearing.
 * Assumes synchronous comparator inputs and a one-cycle switching tick.
 */
`include "lbfm_cfg.svh"
module lbfm_fault_mgr (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Switching clock tick and dimming input
   input wire logic sw_tick,
   input wire logic dim_in,
   // Comparator results
   input wire lbfm_pkg::lbfm_sense_t sense,
   // Drives and status
   output lbfm_pkg::lbfm_drive_t drive,
   output lbfm_pkg::lbfm_ch_t removed_ch,
   output lbfm_pkg::lbfm_state_t state
);
   timeunit 1ns;
   timeprecision 1ns;
   import lbfm_pkg::*;

   lbfm_state_t st_q;
   lbfm_ch_t short_rm_q;
   lbfm_ch_t open_rm_q;
   logic dim_q;
   logic ilim_q;
   logic uv_done;
   logic dim_done;
   logic dim_rise;
   logic latch_ev;
   logic clear_ev;
   logic any_reg;

   assign dim_rise = dim_in && !dim_q;
   assign any_reg = |sense.ch_in_reg;
   assign latch_ev = sense.sw_node_ov || sense.sw_ilim2 || sense.in_ocp;
   assign clear_ev = dim_done || uv_done;

   lbfm_run_cnt #(.LIMIT(16'(`LBFM_DIM_LOW_CYCLES))) dim_cnt (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(sw_tick),
      .cond(!dim_in),
      .done(dim_done)
   );

   lbfm_run_cnt #(.LIMIT(16'(`LBFM_UV_FILTER_CYC))) uv_cnt (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(1'b1),
      .cond(sense.uv_low),
      .done(uv_done)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dim_q <= 1'b0;
      end else begin
         dim_q <= dim_in;
      end
   end

   // truncate only the cycle in which the limit is hit
   always_ff @(posedge clk_sys) begin
      if (rst || sw_tick) begin
         ilim_q <= 1'b0;
      end else if (sense.sw_ilim) begin
         ilim_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= LBFM_SHUTDOWN;
      end else if (clear_ev) begin
         st_q <= LBFM_SHUTDOWN;
      end else begin
         case (st_q)
            LBFM_SHUTDOWN: begin
               if (dim_in) begin
                  st_q <= LBFM_DETECT;
               end
            end
            LBFM_DETECT: begin
               if (sense.sw_ilim2 || sense.in_ocp) begin
                  st_q <= LBFM_LATCHED;
               end else begin
                  st_q <= LBFM_RUN;
               end
            end
            LBFM_RUN: begin
               if (latch_ev) begin
                  st_q <= LBFM_LATCHED;
               end else if (sense.out_ov) begin
                  st_q <= LBFM_OV_HOLD;
               end
            end
            LBFM_OV_HOLD: begin
               if (latch_ev) begin
                  st_q <= LBFM_LATCHED;
               end else if (sense.out_low) begin
                  st_q <= LBFM_RUN;
               end
            end
            LBFM_LATCHED: st_q <= LBFM_LATCHED;
            default: st_q <= LBFM_SHUTDOWN;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || clear_ev) begin
         short_rm_q <= '0;
      end else if (dim_rise) begin
         short_rm_q <= any_reg ? (short_rm_q & sense.ch_short) : '0;
      end else if (any_reg && (st_q == LBFM_RUN || st_q == LBFM_OV_HOLD)) begin
         short_rm_q <= short_rm_q | sense.ch_short;
      end
   end

   // open string removed during overvoltage hold
   always_ff @(posedge clk_sys) begin
      if (rst || clear_ev) begin
         open_rm_q <= '0;
      end else if (st_q == LBFM_OV_HOLD) begin
         open_rm_q <= open_rm_q | sense.ch_open;
      end
   end

   always_comb begin
      drive.fault_n = (st_q != LBFM_LATCHED);
      drive.disc_gate_on = (st_q != LBFM_LATCHED) && (st_q != LBFM_SHUTDOWN) && !sense.in_ocp;
      drive.boost_on = (st_q == LBFM_RUN) && dim_in && !latch_ev && !ilim_q && !sense.sw_ilim;
      if ((st_q == LBFM_RUN || st_q == LBFM_OV_HOLD) && dim_in) begin
         drive.sink_en = ~(short_rm_q | open_rm_q);
      end else begin
         drive.sink_en = '0;
      end
   end

   assign removed_ch = short_rm_q | open_rm_q;
   assign state = st_q;

   latch_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LBFM_LATCHED && !clear_ev |=> st_q == LBFM_LATCHED) else $error("latch left without clear");
   latch_outs_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LBFM_LATCHED |-> !drive.boost_on && drive.sink_en == '0 && !drive.disc_gate_on && !drive.fault_n)
      else $error("latched drives not off");
   ocp_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      sense.in_ocp |-> !drive.disc_gate_on) else $error("gate on during input overcurrent");
   ocp_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
      sense.in_ocp && st_q == LBFM_RUN && !clear_ev |=> st_q == LBFM_LATCHED ##1 !drive.fault_n)
      else $error("input overcurrent not latched");
   ov_nolatch_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LBFM_RUN && sense.out_ov && !latch_ev && !clear_ev |=> st_q == LBFM_OV_HOLD && drive.fault_n)
      else $error("overvoltage handling wrong");
   ov_resume_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LBFM_OV_HOLD && sense.out_low && !latch_ev && !clear_ev |=> st_q == LBFM_RUN)
      else $error("no resume after overvoltage");
   ilim_cycle_a: assert property (@(posedge clk_sys) disable iff (rst)
      sense.sw_ilim && st_q == LBFM_RUN |-> drive.fault_n && drive.disc_gate_on == !sense.in_ocp)
      else $error("cycle limit touched flag or gate");
   dim_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      dim_done |=> st_q == LBFM_SHUTDOWN && short_rm_q == '0) else $error("dimming shutdown did not clear");
   short_rm_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LBFM_RUN && any_reg && !dim_rise && !clear_ev |=> (short_rm_q & $past(sense.ch_short)) == $past(sense.ch_short))
      else $error("short channel not removed");
   all_high_a: assert property (@(posedge clk_sys) disable iff (rst)
      !any_reg && !dim_rise && !clear_ev |=> short_rm_q == $past(short_rm_q)) else $error("removal without regulation");

   // Bound for the input overcurrent shutdown, in system cycles.
   localparam int IOC_MAX = `LBFM_IOC_BOUND_CYC;
   ocp_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
      sense.in_ocp && st_q != LBFM_SHUTDOWN |-> ##[1:IOC_MAX] (!drive.fault_n || st_q == LBFM_SHUTDOWN))
      else $error("input overcurrent not shut down in time");
   sec_ilim_a: assert property (@(posedge clk_sys) disable iff (rst)
      sense.sw_ilim2 |-> !drive.boost_on) else $error("boost on during secondary limit");
   ilim_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      sense.sw_ilim && !sw_tick |=> ilim_q && !drive.boost_on) else $error("truncation not held to cycle end");
   ilim_next_a: assert property (@(posedge clk_sys) disable iff (rst)
      sw_tick |=> !ilim_q) else $error("truncation spilled into next cycle");
   detect_run_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LBFM_DETECT && !sense.sw_ilim2 && !sense.in_ocp && !clear_ev |=> st_q == LBFM_RUN)
      else $error("detection did not hand over to run");
   open_rm_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LBFM_OV_HOLD && !clear_ev |=> (open_rm_q & $past(sense.ch_open)) == $past(sense.ch_open))
      else $error("open string not removed");
   recheck_a: assert property (@(posedge clk_sys) disable iff (rst)
      dim_rise && any_reg && !clear_ev |=> short_rm_q == ($past(short_rm_q) & $past(sense.ch_short)))
      else $error("recheck did not restore cleared channels");

   cov_latch_c: cover property (@(posedge clk_sys) st_q == LBFM_LATCHED ##1 st_q == LBFM_SHUTDOWN);
   cov_ov_c: cover property (@(posedge clk_sys) st_q == LBFM_OV_HOLD ##1 st_q == LBFM_RUN);
   cov_recheck_c: cover property (@(posedge clk_sys) dim_rise && short_rm_q != '0);
   cov_open_c: cover property (@(posedge clk_sys) st_q == LBFM_OV_HOLD && sense.ch_open != '0);
   cov_trunc_c: cover property (@(posedge clk_sys) ilim_q && !sense.sw_ilim);
endmodule : lbfm_fault_mgr

// File: hw/lbfm_cfg.svh
/*
 * Constants for the LED boost fault manager: channel count, timing figures
 * and the cycle counts derived from them.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef LBFM_CFG_SVH
`define LBFM_CFG_SVH

`define LBFM_NUM_CH 4
`define LBFM_CLK_MHZ 20
// Dimming-low shutdown time in switching clock cycles.
`define LBFM_DIM_LOW_CYCLES 32750
// Undervoltage filter time in microseconds, then in system cycles (longer than this disables).
`define LBFM_UV_FILTER_US 50
`define LBFM_UV_FILTER_CYC (`LBFM_UV_FILTER_US * `LBFM_CLK_MHZ)
// Input overcurrent shutdown bound in microseconds, then in system cycles (rounded down).
`define LBFM_IOC_BOUND_US 3
`define LBFM_IOC_BOUND_CYC (`LBFM_IOC_BOUND_US * `LBFM_CLK_MHZ)
`define LBFM_CNT_W 16

`endif

// File: hw/lbfm_pkg.sv
/*
 * Types shared by the fault manager and its filter counter.
 * Assumes lbfm_cfg.svh supplies the sizes.
 */
`include "lbfm_cfg.svh"
package lbfm_pkg;
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [`LBFM_NUM_CH-1:0] lbfm_ch_t;
   // Comparator results, all synchronous to clk_sys.
   typedef struct packed {
      lbfm_ch_t ch_short;
      lbfm_ch_t ch_in_reg;
      lbfm_ch_t ch_open;
      logic out_ov;
      logic out_low;
      logic sw_node_ov;
      logic sw_ilim;
      logic sw_ilim2;
      logic in_ocp;
      logic uv_low;
   } lbfm_sense_t;
   typedef struct packed {
      logic boost_on;
      lbfm_ch_t sink_en;
      logic disc_gate_on;
      logic fault_n;
   } lbfm_drive_t;
   typedef enum logic [2:0] {LBFM_SHUTDOWN, LBFM_DETECT, LBFM_RUN, LBFM_OV_HOLD, LBFM_LATCHED} lbfm_state_t;
endpackage : lbfm_pkg

// File: hw/lbfm_run_cnt.sv
/*
 * Saturating run-length counter: counts ticks while cond is high, clears
 * when it drops, and raises done once the count reaches the limit.
 * Assumes synchronous active-high reset on clk_sys.
 */
`include "lbfm_cfg.svh"
module lbfm_run_cnt #(
   parameter logic [`LBFM_CNT_W-1:0] LIMIT = 16'h0001
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Counting
   input wire logic tick,
   input wire logic cond,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ns;
   import lbfm_pkg::*;
   logic [`LBFM_CNT_W-1:0] cnt_q;

   always_ff @(posedge clk_sys) begin
      if (rst || !cond) begin
         cnt_q <= '0;
      end else if (tick && cnt_q != LIMIT) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   assign done = cond && (cnt_q == LIMIT);

   cnt_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
      !cond |=> cnt_q == '0) else $error("run counter did not restart");
endmodule : lbfm_run_cnt

// File: verif/lbfm_plant_model.sv
/*
 * Partner model: boost stage, LED strings and comparators as the fault manager sees them.
 * Assumes the bench sets the wanted comparator levels on cmd, changed just after a clock edge.
 */
module lbfm_plant_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Bench control
   input wire logic fast,
   input wire lbfm_pkg::lbfm_sense_t cmd,
   // Towards the fault manager
   output lbfm_pkg::lbfm_sense_t sense,
   output logic sw_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   import lbfm_pkg::*;
   logic div_q;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q <= 1'b0;
      end else begin
         div_q <= ~div_q;
      end
   end
   // Half-rate switching; fast ticks every cycle so the long count fits the run.
   assign sw_tick = fast | div_q;
   assign sense = cmd;
endmodule : lbfm_plant_model

// File: verif/lbfm_fault_mgr_tb.sv
/*
 * Self-checking bench for the LED boost fault manager.
 * Assumes the package, config header and partner model are compiled first.
 */
`include "lbfm_cfg.svh"
module lbfm_fault_mgr_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lbfm_pkg::*;
   localparam int DIM = `LBFM_DIM_LOW_CYCLES;
   localparam int UVC = `LBFM_UV_FILTER_CYC;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic dim_in = 1'b0;
   logic fast = 1'b0;
   logic sw_tick;
   lbfm_sense_t cmd = '0;
   lbfm_sense_t sense;
   lbfm_drive_t drive;
   lbfm_ch_t removed_ch;
   lbfm_state_t state;
   int n_errors = 0;
   int n_compared = 0;
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   lbfm_plant_model lbfm_plant_model_inst (.clk_sys(clk_sys), .rst(rst), .fast(fast), .cmd(cmd), .sense(sense),
      .sw_tick(sw_tick));
   lbfm_fault_mgr lbfm_fault_mgr_inst (.clk_sys(clk_sys), .rst(rst), .sw_tick(sw_tick), .dim_in(dim_in),
      .sense(sense), .drive(drive), .removed_ch(removed_ch), .state(state));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic st(input lbfm_state_t e);
      chk("state", 8'(e), 8'(state));
   endtask : st
   task automatic go();
      dim_in = 1'b1;
      cyc(1);
      st(LBFM_DETECT);
      cyc(1);
      st(LBFM_RUN);
   endtask : go
   // Drive word is boost, four sinks, disconnect gate, fault flag.
   task automatic latched();
      st(LBFM_LATCHED);
      chk("drive", 8'h00, 8'(drive));
   endtask : latched
   task automatic uv_clear();
      dim_in = 1'b0;
      cmd.uv_low = 1'b1;
      cyc(UVC + 3);
      st(LBFM_SHUTDOWN);
      cmd.uv_low = 1'b0;
   endtask : uv_clear
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #(70000 * 50);
      n_errors++;
      give_verdict();
   end
   initial begin
      cyc(3);
      rst = 1'b0;
      st(LBFM_SHUTDOWN);
      chk("drive", 8'h01, 8'(drive));
      cmd.ch_in_reg = 4'hF;
      go();
      chk("drive", 8'h7F, 8'(drive));
      cmd.ch_short = 4'h2;
      cyc(2);
      chk("removed", 8'h02, 8'(removed_ch));
      chk("drive", 8'h77, 8'(drive));
      cmd.ch_short = 4'h0;
      cyc(2);
      chk("removed", 8'h02, 8'(removed_ch));
      dim_in = 1'b0;
      cyc(1);
      dim_in = 1'b1;
      cyc(2);
      chk("removed", 8'h00, 8'(removed_ch));
      cmd.ch_in_reg = 4'h0;
      cmd.ch_short = 4'h4;
      cyc(2);
      chk("removed", 8'h00, 8'(removed_ch));
      cmd.ch_in_reg = 4'hF;
      cmd.ch_short = 4'h0;
      cmd.out_ov = 1'b1;
      cyc(1);
      st(LBFM_OV_HOLD);
      chk("drive", 8'h3F, 8'(drive));
      cmd.ch_open = 4'h8;
      cyc(2);
      chk("removed", 8'h08, 8'(removed_ch));
      cmd.ch_open = 4'h0;
      cmd.out_ov = 1'b0;
      cmd.out_low = 1'b1;
      cyc(2);
      chk("drive", 8'h5F, 8'(drive));
      cmd.out_low = 1'b0;
      cmd.out_ov = 1'b1;
      cyc(1);
      st(LBFM_OV_HOLD);
      cmd.out_ov = 1'b0;
      cmd.out_low = 1'b1;
      cyc(2);
      cmd.out_low = 1'b0;
      // The limit must meet an edge without a switching tick.
      while (sw_tick) begin
         cyc(1);
      end
      cmd.sw_ilim = 1'b1;
      #1;
      chk("boost gate flag", 8'h03, {5'h0, drive.boost_on, drive.disc_gate_on, drive.fault_n});
      chk("sinks", 8'h07, 8'(drive.sink_en));
      cyc(1);
      cmd.sw_ilim = 1'b0;
      chk("boost held off", 8'h00, 8'(drive.boost_on));
      cyc(1);
      chk("boost next cycle", 8'h01, 8'(drive.boost_on));
      cyc(3);
      chk("boost", 8'h01, 8'(drive.boost_on));
      cmd.sw_node_ov = 1'b1;
      cyc(1);
      cmd.sw_node_ov = 1'b0;
      latched();
      cyc(5);
      latched();
      cmd.uv_low = 1'b1;
      cyc(UVC - 10);
      cmd.uv_low = 1'b0;
      cyc(1);
      st(LBFM_LATCHED);
      uv_clear();
      cmd.sw_node_ov = 1'b1;
      go();
      cyc(1);
      latched();
      cmd.sw_node_ov = 1'b0;
      uv_clear();
      go();
      cmd.in_ocp = 1'b1;
      #1;
      chk("gate", 8'h00, 8'(drive.disc_gate_on));
      cyc(1);
      cmd.in_ocp = 1'b0;
      latched();
      uv_clear();
      go();
      cmd.sw_ilim2 = 1'b1;
      cyc(1);
      cmd.sw_ilim2 = 1'b0;
      latched();
      fast = 1'b1;
      // host holds dimming low to clear.
      dim_in = 1'b0;
      cyc(20000);
      dim_in = 1'b1;
      cyc(2);
      dim_in = 1'b0;
      cyc(20000);
      st(LBFM_LATCHED);
      cyc(DIM - 20000 - 1);
      st(LBFM_LATCHED);
      cyc(2);
      st(LBFM_SHUTDOWN);
      give_verdict();
   end
endmodule : lbfm_fault_mgr_tb
